// ===== src/bypass_fault.sv
// mode control, i2c pass-through switch and fault status registers
`timescale 1ns/1ps
`include "bypass_fault_defines.svh"

module bypass_fault #(
   parameter int SENSORS = 3
) (
   input wire logic sys_clk,
   input wire logic nrst,
   // register port from the host i2c slave
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // host i2c bus pins, open drain
   input wire logic host_scl_i,
   input wire logic host_sda_i,
   output logic host_sda_o,
   output logic host_sda_oe,
   // sensor i2c bus pins, open drain
   input wire logic sensor_scl_i,
   input wire logic sensor_sda_i,
   output logic sensor_scl_o,
   output logic sensor_scl_oe,
   output logic sensor_sda_o,
   output logic sensor_sda_oe,
   // own bus engines when not in pass-through
   input wire logic slave_sda_oe,
   input wire logic master_scl_oe,
   input wire logic master_sda_oe,
   // events from the rest of the device
   input wire logic config_loaded,
   input wire logic rom_load_fail,
   input wire logic power_fault,
   input wire logic watchdog_fault,
   input wire logic [SENSORS-1:0] sensor_noack,
   input wire logic [SENSORS-1:0] sensor_id_bad,
   input wire logic fault_strobe,
   input wire logic [3:0] fault_kind,
   // mode outputs
   output logic algo_run,
   output logic sensors_on,
   output logic host_int,
   output logic bypass_active,
   output logic processor_restart
);

   bypass_fault_pkg::dev_state_e state_q, state_d;
   bypass_fault_pkg::dev_state_e prior_q;
   logic [7:0] event_flags_q;
   logic [SENSORS-1:0] noack_q;
   logic [SENSORS-1:0] idbad_q;
   logic rom_load_fail_flag_q;
   logic [7:0] error_code_q;
   logic [7:0] algorithm_settings_q;
   logic [7:0] bypass_settings_q;
   logic [7:0] rate_q [SENSORS];
   logic [7:0] reg_rdata_q;
   logic host_sda_oe_q, sensor_scl_oe_q, sensor_sda_oe_q;
   logic algo_run_q, sensors_on_q, host_int_q, bypass_q, restart_q;
   logic hw_fault, restart_cmd, wr_algo, wr_bypass, rd_event;
   logic [7:0] sensor_fault_flags, device_condition, algorithm_state, bypass_state;

   // maps a reported fault kind to the code shown to the host
   function automatic logic [7:0] code_of(input logic [3:0] kind);
      logic [7:0] c;
      c = `ERR_NONE;
      unique case (kind)
         bypass_fault_pkg::FK_BAD_RATE: c = `ERR_BAD_RATE;
         bypass_fault_pkg::FK_MATH: c = `ERR_MATH;
         bypass_fault_pkg::FK_MAG_INIT: c = `ERR_MAG_INIT;
         bypass_fault_pkg::FK_ACC_INIT: c = `ERR_ACC_INIT;
         bypass_fault_pkg::FK_GYR_INIT: c = `ERR_GYR_INIT;
         bypass_fault_pkg::FK_MAG_RATE: c = `ERR_MAG_RATE;
         bypass_fault_pkg::FK_ACC_RATE: c = `ERR_ACC_RATE;
         bypass_fault_pkg::FK_GYR_RATE: c = `ERR_GYR_RATE;
         default: c = `ERR_NONE; // unknown kinds read as no error
      endcase
      return c;
   endfunction

   // true when the address hits the given register, on a read or a write
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction

   // decoded strobes
   assign hw_fault = rom_load_fail | power_fault | watchdog_fault;
   assign restart_cmd = reg_wr && hit(reg_addr, `OFS_RESTART_REQ)
      && reg_wdata == `VAL_RESTART;
   assign wr_algo = reg_wr && hit(reg_addr, `OFS_ALGO_SETTINGS);
   assign wr_bypass = reg_wr && hit(reg_addr, `OFS_BYPASS_SETTINGS);
   assign rd_event = reg_rd && hit(reg_addr, `OFS_EVENT_FLAGS);

   // status views assembled from state and sticky flags
   always_comb begin
      sensor_fault_flags = `RST_BYTE;
      sensor_fault_flags[`SENSOR_NOACK_LSB +: SENSORS] = noack_q;
      sensor_fault_flags[`SENSOR_IDERR_LSB +: SENSORS] = idbad_q;
      device_condition = `RST_BYTE;
      device_condition[`BIT_ROM_LOAD_FAIL] = rom_load_fail_flag_q;
      device_condition[`BIT_IDLE] = state_q == bypass_fault_pkg::ST_INITIALIZED
         || state_q == bypass_fault_pkg::ST_UNPROGRAMMED;
      algorithm_state = `RST_BYTE;
      algorithm_state[`BIT_SLEEP_REQUEST] = state_q == bypass_fault_pkg::ST_STANDBY;
      bypass_state = `RST_BYTE;
      bypass_state[`BIT_BYPASS_ENABLE] = state_q == bypass_fault_pkg::ST_BYPASS;
   end

   // next operating state; restart beats faults, faults beat host writes outside pass-through
   always_comb begin
      state_d = state_q;
      if (restart_cmd) begin
         state_d = bypass_fault_pkg::ST_UNPROGRAMMED;
      end else if (state_q == bypass_fault_pkg::ST_BYPASS) begin
         // faults in pass-through are recorded in prior_q, the host owns the bus
         if (wr_bypass && !reg_wdata[`BIT_BYPASS_ENABLE]) begin
            state_d = prior_q;
         end
      end else if (hw_fault) begin
         state_d = bypass_fault_pkg::ST_STANDBY;
      end else if (wr_bypass && reg_wdata[`BIT_BYPASS_ENABLE]) begin
         // normal operation refuses the request and keeps its state
         if (state_q != bypass_fault_pkg::ST_NORMAL) begin
            state_d = bypass_fault_pkg::ST_BYPASS;
         end
      end else if (wr_algo) begin
         if (reg_wdata[`BIT_SLEEP_REQUEST]) begin
            if (state_q != bypass_fault_pkg::ST_UNPROGRAMMED) begin
               state_d = bypass_fault_pkg::ST_STANDBY;
            end
         end else if (state_q == bypass_fault_pkg::ST_STANDBY) begin
            state_d = bypass_fault_pkg::ST_NORMAL;
         end
      end else if (config_loaded && state_q == bypass_fault_pkg::ST_UNPROGRAMMED) begin
         state_d = bypass_fault_pkg::ST_INITIALIZED;
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= bypass_fault_pkg::ST_UNPROGRAMMED;
      end else begin
         state_q <= state_d;
      end
   end

   // state held before pass-through; a fault meanwhile turns it to standby
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prior_q <= bypass_fault_pkg::ST_UNPROGRAMMED;
      end else if (state_q != bypass_fault_pkg::ST_BYPASS) begin
         prior_q <= state_q;
      end else if (hw_fault) begin
         prior_q <= bypass_fault_pkg::ST_STANDBY;
      end
   end

   // algorithm settings; a hardware fault also raises the sleep request
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         algorithm_settings_q <= `RST_BYTE;
      end else if (restart_cmd) begin
         algorithm_settings_q <= `RST_BYTE;
      end else if (hw_fault) begin
         algorithm_settings_q[`BIT_SLEEP_REQUEST] <= 1'b1;
      end else if (wr_algo) begin
         algorithm_settings_q <= reg_wdata;
      end
   end

   // bypass settings keep the written value, refused or not
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bypass_settings_q <= `RST_BYTE;
      end else if (restart_cmd) begin
         bypass_settings_q <= `RST_BYTE;
      end else if (wr_bypass) begin
         bypass_settings_q <= reg_wdata;
      end
   end

   // sensor rate settings; lost on a hardware fault, untouched by pass-through
   genvar gi;
   generate
      for (gi = 0; gi < SENSORS; gi++) begin : g_rate
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               rate_q[gi] <= `RST_BYTE;
            end else if (hw_fault) begin
               rate_q[gi] <= `RATE_LOST;
            end else if (reg_wr && hit(reg_addr, `OFS_MAG_RATE + 8'(gi))) begin
               rate_q[gi] <= reg_wdata;
            end
         end
      end
   endgenerate

   // event flags: hardware set wins over the clear by a read
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         event_flags_q <= `RST_BYTE;
      end else begin
         event_flags_q <= rd_event ? `RST_BYTE : event_flags_q;
         if (restart_q) begin
            event_flags_q[`BIT_EV_RESTARTED] <= 1'b1;
         end
         if (hw_fault || fault_strobe || |sensor_noack || |sensor_id_bad) begin
            event_flags_q[`BIT_EV_ERROR] <= 1'b1;
         end
      end
   end

   // sticky sensor faults, cleared only by a restart
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         noack_q <= '0;
         idbad_q <= '0;
      end else begin
         noack_q <= (restart_cmd ? '0 : noack_q) | sensor_noack;
         idbad_q <= (restart_cmd ? '0 : idbad_q) | sensor_id_bad;
      end
   end

   // rom load failure flag and latest software fault code
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rom_load_fail_flag_q <= 1'b0;
         error_code_q <= `ERR_NONE;
      end else begin
         rom_load_fail_flag_q <= (rom_load_fail_flag_q && !restart_cmd) || rom_load_fail;
         if (fault_strobe) begin
            error_code_q <= code_of(fault_kind);
         end else if (restart_cmd) begin
            error_code_q <= `ERR_NONE;
         end
      end
   end

   // read data is captured at the read strobe, before any clear
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata_q <= `RST_BYTE;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `OFS_EVENT_FLAGS: reg_rdata_q <= event_flags_q;
            `OFS_SENSOR_FAULT: reg_rdata_q <= sensor_fault_flags;
            `OFS_DEVICE_COND: reg_rdata_q <= device_condition;
            `OFS_ALGO_STATE: reg_rdata_q <= algorithm_state;
            `OFS_ERROR_CODE: reg_rdata_q <= error_code_q;
            `OFS_ALGO_SETTINGS: reg_rdata_q <= algorithm_settings_q;
            `OFS_MAG_RATE: reg_rdata_q <= rate_q[0];
            `OFS_ACC_RATE: reg_rdata_q <= rate_q[1];
            `OFS_GYR_RATE: reg_rdata_q <= rate_q[2];
            `OFS_BYPASS_STATE: reg_rdata_q <= bypass_state;
            `OFS_BYPASS_SETTINGS: reg_rdata_q <= bypass_settings_q;
            default: reg_rdata_q <= `RST_BYTE; // unmapped reads as zero
         endcase
      end
   end

   // pass-through switch; one flop of latency, fine for the 10 MHz clock
   // against standard and fast i2c, too slow for high-speed mode.
   // the sensor-to-host path ignores lows we drive ourselves to avoid latch-up
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sensor_scl_oe_q <= 1'b0;
         sensor_sda_oe_q <= 1'b0;
         host_sda_oe_q <= 1'b0;
      end else if (state_d == bypass_fault_pkg::ST_BYPASS) begin
         sensor_scl_oe_q <= !host_scl_i;
         sensor_sda_oe_q <= !host_sda_i && !host_sda_oe_q;
         host_sda_oe_q <= !sensor_sda_i && !sensor_sda_oe_q;
      end else begin
         sensor_scl_oe_q <= master_scl_oe;
         sensor_sda_oe_q <= master_sda_oe;
         host_sda_oe_q <= slave_sda_oe;
      end
   end

   // mode outputs; interrupt is held off in pass-through and returns on exit
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         algo_run_q <= 1'b0;
         sensors_on_q <= 1'b0;
         host_int_q <= 1'b0;
         bypass_q <= 1'b0;
         restart_q <= 1'b0;
      end else begin
         algo_run_q <= state_d == bypass_fault_pkg::ST_NORMAL;
         sensors_on_q <= state_d == bypass_fault_pkg::ST_NORMAL;
         // next state, so the interrupt drops on the same edge that pass-through starts
         host_int_q <= |event_flags_q && !rd_event
            && state_d != bypass_fault_pkg::ST_BYPASS;
         bypass_q <= state_d == bypass_fault_pkg::ST_BYPASS;
         restart_q <= restart_cmd;
      end
   end

   assign reg_rdata = reg_rdata_q;
   // open-drain pins only ever drive low
   assign host_sda_o = 1'b0;
   assign sensor_scl_o = 1'b0;
   assign sensor_sda_o = 1'b0;
   assign host_sda_oe = host_sda_oe_q;
   assign sensor_scl_oe = sensor_scl_oe_q;
   assign sensor_sda_oe = sensor_sda_oe_q;
   assign algo_run = algo_run_q;
   assign sensors_on = sensors_on_q;
   assign host_int = host_int_q;
   assign bypass_active = bypass_q;
   assign processor_restart = restart_q;

endmodule

// ===== src/bypass_fault_defines.svh
// register offsets, field positions, codes and reset values of the mode and fault block
`ifndef BYPASS_FAULT_DEFINES_SVH
`define BYPASS_FAULT_DEFINES_SVH
// register offsets on the host register port
`define OFS_EVENT_FLAGS 8'h35
`define OFS_SENSOR_FAULT 8'h36
`define OFS_DEVICE_COND 8'h37
`define OFS_ALGO_STATE 8'h38
`define OFS_ERROR_CODE 8'h50
`define OFS_ALGO_SETTINGS 8'h54
`define OFS_MAG_RATE 8'h55
`define OFS_ACC_RATE 8'h56
`define OFS_GYR_RATE 8'h57
`define OFS_RESTART_REQ 8'h9b
`define OFS_BYPASS_STATE 8'h9e
`define OFS_BYPASS_SETTINGS 8'ha0
// command values and field positions
`define VAL_ENABLE 8'h01
`define VAL_DISABLE 8'h00
`define VAL_RESTART 8'h01
`define BIT_SLEEP_REQUEST 0
`define BIT_BYPASS_ENABLE 0
`define BIT_EV_RESTARTED 0
`define BIT_EV_ERROR 1
`define BIT_ROM_LOAD_FAIL 2
`define BIT_IDLE 3
`define SENSOR_NOACK_LSB 0
`define SENSOR_IDERR_LSB 4
// error codes
`define ERR_NONE 8'h00
`define ERR_BAD_RATE 8'h80
`define ERR_MATH 8'h30
`define ERR_MAG_INIT 8'h21
`define ERR_ACC_INIT 8'h22
`define ERR_GYR_INIT 8'h24
`define ERR_MAG_RATE 8'h11
`define ERR_ACC_RATE 8'h12
`define ERR_GYR_RATE 8'h14
// reset values
`define RST_BYTE 8'h00
`define RATE_LOST 8'h00
`endif

// ===== src/bypass_fault_pkg.sv
// types used by the mode and fault block; its bench does not import them
package bypass_fault_pkg;
   // device operating states, one-hot
   typedef enum logic [4:0] {
      ST_UNPROGRAMMED = 5'b00001,
      ST_INITIALIZED = 5'b00010,
      ST_NORMAL = 5'b00100,
      ST_STANDBY = 5'b01000,
      ST_BYPASS = 5'b10000
   } dev_state_e;
   // kinds of software fault reported by the algorithm core
   typedef enum logic [3:0] {
      FK_NONE = 4'h0,
      FK_BAD_RATE = 4'h1,
      FK_MATH = 4'h2,
      FK_MAG_INIT = 4'h3,
      FK_ACC_INIT = 4'h4,
      FK_GYR_INIT = 4'h5,
      FK_MAG_RATE = 4'h6,
      FK_ACC_RATE = 4'h7,
      FK_GYR_RATE = 4'h8
   } fault_kind_e;
endpackage

// ===== testbench/bypass_fault_checker.sv
// concurrent checks on the ports of the mode and fault block
`timescale 1ns/1ps
module bypass_fault_checker (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic host_scl_i,
   input wire logic host_sda_i,
   input wire logic host_sda_oe,
   input wire logic sensor_sda_i,
   input wire logic sensor_scl_oe,
   input wire logic sensor_sda_oe,
   input wire logic rom_load_fail,
   input wire logic power_fault,
   input wire logic watchdog_fault,
   input wire logic algo_run,
   input wire logic sensors_on,
   input wire logic host_int,
   input wire logic bypass_active,
   input wire logic processor_restart
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic hw_f;
   // any hardware fault pulse
   assign hw_f = rom_load_fail | power_fault | watchdog_fault;
   // pass-through silences algorithm, sensors and interrupt
   AST_BYPASS_MUTE: assert property (bypass_active |-> !algo_run && !sensors_on && !host_int)
      else $error("outputs active during pass-through");
   // switch is one cycle late, so compare against last cycle's bus lines
   AST_SCL_LINK: assert property (bypass_active |-> sensor_scl_oe == !$past(host_scl_i))
      else $error("sensor clock not following host clock");
   AST_SDA_LINK: assert property (bypass_active |->
      host_sda_oe == (!$past(sensor_sda_i) && !$past(sensor_sda_oe)))
      else $error("host data not following sensor data");
   AST_SDA_DOWN: assert property (bypass_active |->
      sensor_sda_oe == (!$past(host_sda_i) && !$past(host_sda_oe)))
      else $error("sensor data not following host data");
   AST_STANDBY_ENTRY: assert property (reg_wr && reg_addr == 8'h54 && reg_wdata == 8'h01
      && algo_run |=> !algo_run && !sensors_on)
      else $error("standby request left algorithm running");
   AST_BYPASS_REFUSE: assert property (reg_wr && reg_addr == 8'ha0 && reg_wdata[0]
      && algo_run |=> !bypass_active)
      else $error("pass-through entered from normal operation");
   AST_BYPASS_EXIT: assert property (bypass_active && reg_wr && reg_addr == 8'ha0
      && !reg_wdata[0] |=> !bypass_active && !algo_run)
      else $error("pass-through exit failed");
   AST_HW_FAULT: assert property (hw_f && !bypass_active && !reg_wr
      |=> !algo_run && !sensors_on ##[0:1] host_int)
      else $error("hardware fault not handled");
   AST_RESTART: assert property (reg_wr && reg_addr == 8'h9b && reg_wdata == 8'h01
      |=> processor_restart ##1 !processor_restart)
      else $error("restart pulse wrong");
   AST_INT_DROP: assert property (reg_rd && reg_addr == 8'h35 && !hw_f
      && !processor_restart && !bypass_active |=> !host_int)
      else $error("interrupt kept after event read");
   // main scenarios reached
   cover property (reg_wr && reg_addr == 8'ha0 && reg_wdata[0] ##1 bypass_active);
   cover property (hw_f && algo_run);
   cover property (processor_restart);
endmodule
bind bypass_fault bypass_fault_checker chk_u (.sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .host_scl_i(host_scl_i),
   .host_sda_i(host_sda_i), .host_sda_oe(host_sda_oe), .sensor_sda_i(sensor_sda_i),
   .sensor_scl_oe(sensor_scl_oe), .sensor_sda_oe(sensor_sda_oe), .rom_load_fail(rom_load_fail),
   .power_fault(power_fault), .watchdog_fault(watchdog_fault), .algo_run(algo_run),
   .sensors_on(sensors_on), .host_int(host_int), .bypass_active(bypass_active),
   .processor_restart(processor_restart));

// ===== testbench/i2c_wires.sv
// host and sensor bus wiring with the host's own pulls and a sensor pull
`timescale 1ns/1ps
module i2c_wires (
   input wire logic host_pull_scl,
   input wire logic host_pull_sda,
   input wire logic sens_pull_sda,
   input wire logic host_sda_oe,
   input wire logic sensor_scl_oe,
   input wire logic sensor_sda_oe,
   output logic host_scl,
   output logic host_sda,
   output logic sensor_scl,
   output logic sensor_sda
);
   // pull-ups: a released line reads high, never a stale driven level
   assign host_scl = !host_pull_scl;
   assign host_sda = !(host_pull_sda | host_sda_oe);
   assign sensor_scl = !sensor_scl_oe;
   assign sensor_sda = !(sens_pull_sda | sensor_sda_oe);
endmodule

// ===== testbench/tb.sv
// self-checking bench of the mode and fault block
`timescale 1ns/1ps
module tb;
   logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
   logic cfg = 1'b0, rom_f = 1'b0, pwr_f = 1'b0, wd_f = 1'b0, f_stb = 1'b0;
   logic [2:0] noack = 3'h0, idbad = 3'h0;
   logic [3:0] f_kind = 4'h0;
   logic h_scl_p = 1'b0, h_sda_p = 1'b0, s_sda_p = 1'b0;
   logic slv_oe = 1'b0, m_scl_oe = 1'b0, m_sda_oe = 1'b0;
   logic h_scl, h_sda, s_scl, s_sda, h_sda_oe, s_scl_oe, s_sda_oe;
   logic algo_run, sensors_on, host_int, bypass_active, processor_restart;
   int errors = 0, checks_done = 0, seed = 33, cyc = 0;
   logic [7:0] offs [12] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h50, 8'h54, 8'h55, 8'h56, 8'h57,
      8'h9e, 8'ha0, 8'h77};

   bypass_fault dut_u (.sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_scl_i(h_scl),
      .host_sda_i(h_sda), .host_sda_o(), .host_sda_oe(h_sda_oe), .sensor_scl_i(s_scl),
      .sensor_sda_i(s_sda), .sensor_scl_o(), .sensor_scl_oe(s_scl_oe), .sensor_sda_o(),
      .sensor_sda_oe(s_sda_oe), .slave_sda_oe(slv_oe), .master_scl_oe(m_scl_oe),
      .master_sda_oe(m_sda_oe), .config_loaded(cfg), .rom_load_fail(rom_f),
      .power_fault(pwr_f), .watchdog_fault(wd_f), .sensor_noack(noack),
      .sensor_id_bad(idbad), .fault_strobe(f_stb), .fault_kind(f_kind), .algo_run(algo_run),
      .sensors_on(sensors_on), .host_int(host_int), .bypass_active(bypass_active),
      .processor_restart(processor_restart));
   i2c_wires bus_u (.host_pull_scl(h_scl_p), .host_pull_sda(h_sda_p), .sens_pull_sda(s_sda_p),
      .host_sda_oe(h_sda_oe), .sensor_scl_oe(s_scl_oe), .sensor_sda_oe(s_sda_oe),
      .host_scl(h_scl), .host_sda(h_sda), .sensor_scl(s_scl), .sensor_sda(s_sda));

   // 10 MHz clock
   always #50 sys_clk = ~sys_clk;

   // expected error code for a fault kind, unknown kinds read as no error
   function automatic logic [7:0] err_exp(input logic [3:0] k);
      logic [7:0] t [9] = '{8'h00, 8'h80, 8'h30, 8'h21, 8'h22, 8'h24, 8'h11, 8'h12, 8'h14};
      return (k < 4'h9) ? t[k] : 8'h00;
   endfunction

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // hang guard, far above the few hundred cycles the tests need
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         test_done();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // single-bit outputs, widened here so no port pads them silently
   task automatic chk_bit(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask

   // one-cycle write strobe; effects are visible when the task returns
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
   endtask

   // read data is registered, so it is looked at one edge after the strobe
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
   endtask

   // one-cycle pulse on {power, watchdog, rom, config, software} and sensor flags
   task automatic pulse(input logic [4:0] p, input logic [2:0] na, input logic [2:0] ib);
      @(posedge sys_clk);
      #1;
      {pwr_f, wd_f, rom_f, cfg, f_stb} = p;
      noack = na;
      idbad = ib;
      @(posedge sys_clk);
      #1;
      {pwr_f, wd_f, rom_f, cfg, f_stb, noack, idbad} = 11'h000;
   endtask

   initial begin
      repeat (10) @(posedge sys_clk);
      #1 nrst = 1'b1;
      foreach (offs[i]) rdc(offs[i], (offs[i] == 8'h37) ? 8'h08 : 8'h00);
      $display("test reset values done");
      // pass-through from unprogrammed with random line traffic
      wr(8'ha0, 8'h01);
      chk_bit(bypass_active, 1'b1);
      repeat (40) begin
         @(posedge sys_clk);
         #1 {h_scl_p, h_sda_p, s_sda_p, slv_oe, m_scl_oe, m_sda_oe} = 6'($random(seed));
         @(posedge sys_clk);
         #1 chk_bit(s_scl_oe, !h_scl);
      end
      {h_scl_p, h_sda_p, s_sda_p} = 3'h0;
      rdc(8'h9e, 8'h01);
      wr(8'ha0, 8'h00);
      rdc(8'h37, 8'h08);
      rdc(8'h9e, 8'h00);
      // switch open again: own engines' enables reach the pins
      chk({5'h00, h_sda_oe, s_scl_oe, s_sda_oe}, {5'h00, slv_oe, m_scl_oe, m_sda_oe});
      $display("test pass-through from unprogrammed done");
      pulse(5'b00010, 3'h0, 3'h0);
      rdc(8'h37, 8'h08);
      wr(8'h54, 8'h01);
      rdc(8'h38, 8'h01);
      wr(8'h54, 8'h00);
      chk_bit(algo_run, 1'b1);
      rdc(8'h38, 8'h00);
      rdc(8'h37, 8'h00);
      wr(8'ha0, 8'h01);
      rdc(8'h9e, 8'h00);
      $display("test standby and refusal done");
      // host order: standby first, then pass-through, leave in reverse
      wr(8'h54, 8'h01);
      // leave an event pending so the interrupt mask in pass-through is exercised
      pulse(5'b00001, 3'h0, 3'h0);
      wr(8'ha0, 8'h01);
      chk({5'h00, host_int, sensors_on, algo_run}, 8'h00);
      v = 8'($random(seed));
      wr(8'h55, v);
      wr(8'ha0, 8'h00);
      rdc(8'h38, 8'h01);
      rdc(8'h55, v);
      rdc(8'h35, 8'h02);
      wr(8'h54, 8'h00);
      chk_bit(algo_run, 1'b1);
      $display("test pass-through from standby done");
      // power, watchdog and rom faults from normal operation
      for (int k = 0; k < 3; k++) begin
         wr(8'h55, 8'h5a);
         pulse(5'b10000 >> k, 3'h0, 3'h0);
         chk_bit(sensors_on, 1'b0);
         @(posedge sys_clk);
         #1 chk_bit(host_int, 1'b1);
         rdc(8'h35, 8'h02);
         rdc(8'h35, 8'h00);
         rdc(8'h55, 8'h00);
         rdc(8'h38, 8'h01);
         rdc(8'h37, (k == 2) ? 8'h04 : 8'h00);
         wr(8'h54, 8'h00);
      end
      $display("test hardware faults done");
      v = 8'($random(seed));
      v[0] = 1'b1; // at least one noack, so the error event must rise
      pulse(5'b00000, v[2:0], v[6:4]);
      rdc(8'h36, {1'b0, v[6:4], 1'b0, v[2:0]});
      rdc(8'h35, 8'h02);
      $display("test sensor flags done");
      for (int k = 0; k < 10; k++) begin
         f_kind = (k == 9) ? 4'h9 + 4'($unsigned($random(seed)) % 7) : 4'(k);
         pulse(5'b00001, 3'h0, 3'h0);
         rdc(8'h50, err_exp(f_kind));
      end
      rdc(8'h35, 8'h02);
      $display("test error codes done");
      wr(8'h9b, 8'h01);
      chk_bit(processor_restart, 1'b1);
      rdc(8'h35, 8'h01);
      rdc(8'h50, 8'h00);
      rdc(8'h36, 8'h00);
      rdc(8'h37, 8'h08);
      rdc(8'h54, 8'h00);
      $display("test restart done");
      test_done();
   end
endmodule
